//--- logic/pomc_core.sv
// pomc_core: offset, mask and gain-boost registers plus the per-cycle
// correction of the proximity result and the sleep-after-interrupt state.
// assumes raw diode samples and cycle strobes come from the analog front end.
`timescale 1ns/100ps
module pomc_core (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // register port
    input wire pomc_pkg::pomc_req_t req,
    output logic [7:0] rdata,
    // front end
    input wire logic cycle_start,
    input wire logic cycle_done,
    input wire logic [7:0] raw_up,
    input wire logic [7:0] raw_down,
    input wire logic [7:0] raw_left,
    input wire logic [7:0] raw_right,
    input wire logic irq_level,
    input wire logic sleep_decision,
    // results
    output logic [7:0] proximity_result,
    output logic result_valid,
    output logic low_power,
    output logic converting
);
    logic [7:0] prox_offset_up_right;
    logic [7:0] prox_offset_down_left;
    logic [7:0] proximity_diode_config;
    pomc_pkg::pomc_cfg_t active_cfg;
    pomc_pkg::pomc_state_t state;
    pomc_pkg::pomc_state_t next_state;

    // one address compare per register, shared by write and read paths
    wire sel_ur = req.addr == pomc_pkg::ADDR_OFFSET_UR;
    wire sel_dl = req.addr == pomc_pkg::ADDR_OFFSET_DL;
    wire sel_cfg = req.addr == pomc_pkg::ADDR_DIODE_CFG;
    wire wr_ur = req.wr && sel_ur;
    wire wr_dl = req.wr && sel_dl;
    wire wr_cfg = req.wr && sel_cfg;
    // reserved bits are not stored, so they read as zero
    wire [7:0] cfg_in = req.wdata & pomc_pkg::CFG_WRITABLE;
    // unmapped addresses read as zero
    wire [7:0] next_rdata =
        sel_ur ? prox_offset_up_right :
        sel_dl ? prox_offset_down_left :
        sel_cfg ? proximity_diode_config : 8'h00;

    // snapshot of the settings at cycle start
    pomc_pkg::pomc_cfg_t snap;
    assign snap = '{
        offset_ur: prox_offset_up_right,
        offset_dl: prox_offset_down_left,
        mask_udlr: proximity_diode_config[pomc_pkg::MASK_UP_BIT:pomc_pkg::MASK_RIGHT_BIT],
        gain_boost: proximity_diode_config[pomc_pkg::BOOST_BIT]
    };
    // sleep enable acts at once; it is not part of a conversion's settings
    wire sleep_en = proximity_diode_config[pomc_pkg::SAI_BIT];

    // masked diodes contribute nothing
    wire [7:0] up_s = active_cfg.mask_udlr[pomc_pkg::MASK_UP_BIT] ? 8'h00 : raw_up;
    wire [7:0] dn_s = active_cfg.mask_udlr[pomc_pkg::MASK_DOWN_BIT] ? 8'h00 : raw_down;
    wire [7:0] lf_s = active_cfg.mask_udlr[pomc_pkg::MASK_LEFT_BIT] ? 8'h00 : raw_left;
    wire [7:0] rt_s = active_cfg.mask_udlr[pomc_pkg::MASK_RIGHT_BIT] ? 8'h00 : raw_right;
    // each diode sample is 8 bits, so a pair sum needs 9 bits
    wire [8:0] pair_ur = {1'b0, up_s} + {1'b0, rt_s};
    wire [8:0] pair_dl = {1'b0, dn_s} + {1'b0, lf_s};

    // sign/magnitude offset removal, per pair
    wire ur_neg = active_cfg.offset_ur[pomc_pkg::SIGN_BIT];
    wire dl_neg = active_cfg.offset_dl[pomc_pkg::SIGN_BIT];
    wire [10:0] ur_mag = {4'h0, active_cfg.offset_ur[6:0]};
    wire [10:0] dl_mag = {4'h0, active_cfg.offset_dl[6:0]};
    wire [10:0] ur_base = {2'b00, pair_ur};
    wire [10:0] dl_base = {2'b00, pair_dl};
    // a negative offset adds its magnitude back
    wire [10:0] ur_corr = ur_neg ? ur_base + ur_mag : ur_base - ur_mag;
    wire [10:0] dl_corr = dl_neg ? dl_base + dl_mag : dl_base - dl_mag;
    // negative after subtraction clamps to zero
    wire [10:0] ur_pos = ur_corr[10] ? 11'h000 : ur_corr;
    wire [10:0] dl_pos = dl_corr[10] ? 11'h000 : dl_corr;
    wire [10:0] pair_total = ur_pos + dl_pos;
    // halving scales the two-pair sum; it can still exceed 8 bits, so the result is clamped below
    wire [10:0] sum_pairs = pair_total >> 1;
    // boost doubles the signal
    wire [10:0] boosted = active_cfg.gain_boost ? {sum_pairs[9:0], 1'b0} : sum_pairs;
    // any masked diode halves reach; limit is 127 unless boosted
    wire any_masked = |active_cfg.mask_udlr;
    wire [7:0] limit = (any_masked && !active_cfg.gain_boost)
        ? pomc_pkg::HALF_SCALE_MAX : pomc_pkg::FULL_SCALE_MAX;
    wire [7:0] next_result = (boosted > {3'b000, limit}) ? limit : boosted[7:0];

    // strobes are only honoured in the state that expects them
    wire take_start = state == pomc_pkg::ST_IDLE && cycle_start;
    wire take_done = state == pomc_pkg::ST_CONV && cycle_done;
    wire take_sleep = sleep_decision && sleep_en && irq_level;

    always_comb begin
        next_state = state;
        case (state)
            pomc_pkg::ST_IDLE: begin
                if (take_sleep) begin
                    next_state = pomc_pkg::ST_SLEEP;
                end else if (cycle_start) begin
                    next_state = pomc_pkg::ST_CONV;
                end
            end
            pomc_pkg::ST_CONV: begin
                if (cycle_done) begin
                    next_state = pomc_pkg::ST_IDLE;
                end
            end
            pomc_pkg::ST_SLEEP: begin
                if (!irq_level) begin
                    next_state = pomc_pkg::ST_IDLE;
                end
            end
            default: next_state = pomc_pkg::ST_IDLE;
        endcase
    end

    // offsets are stored whole; the sign rides in bit 7
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prox_offset_up_right <= pomc_pkg::RST_OFFSET_UR;
        end else if (wr_ur) begin
            prox_offset_up_right <= req.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prox_offset_down_left <= pomc_pkg::RST_OFFSET_DL;
        end else if (wr_dl) begin
            prox_offset_down_left <= req.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            proximity_diode_config <= pomc_pkg::RST_DIODE_CFG;
        end else if (wr_cfg) begin
            proximity_diode_config <= cfg_in;
        end
    end

    // a write in the start cycle lands only in the next cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            active_cfg <= '0;
        end else if (take_start) begin
            active_cfg <= snap;
        end
    end

    // one-hot state register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= pomc_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            result_valid <= 1'b0;
        end else begin
            result_valid <= take_done;
        end
    end

    // result holds until the next conversion ends
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            proximity_result <= 8'h00;
        end else if (take_done) begin
            proximity_result <= next_result;
        end
    end

    // read data holds until the next read strobe
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            rdata <= next_rdata;
        end
    end

    // registered from next_state so the pin changes with the state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            low_power <= 1'b0;
        end else begin
            low_power <= next_state == pomc_pkg::ST_SLEEP;
        end
    end

    // converting mirrors the state for the front end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            converting <= 1'b0;
        end else begin
            converting <= next_state == pomc_pkg::ST_CONV;
        end
    end
endmodule

//--- inc/pomc_pkg.sv
// pomc_pkg: register map, field positions and carriers for the proximity
// offset / mask configuration block.
// assumes a byte-wide register port decoded by the serial front end.
package pomc_pkg;
    localparam logic [7:0] ADDR_OFFSET_UR = 8'h9D;
    localparam logic [7:0] ADDR_OFFSET_DL = 8'h9E;
    localparam logic [7:0] ADDR_DIODE_CFG = 8'h9F;
    localparam logic [7:0] RST_OFFSET_UR = 8'h00;
    localparam logic [7:0] RST_OFFSET_DL = 8'h00;
    localparam logic [7:0] RST_DIODE_CFG = 8'h00;
    localparam int SIGN_BIT = 7;
    localparam int BOOST_BIT = 5;
    localparam int SAI_BIT = 4;
    localparam int MASK_UP_BIT = 3;
    localparam int MASK_DOWN_BIT = 2;
    localparam int MASK_LEFT_BIT = 1;
    localparam int MASK_RIGHT_BIT = 0;
    localparam logic [7:0] CFG_WRITABLE = 8'h3F;
    localparam logic [7:0] HALF_SCALE_MAX = 8'h7F;
    localparam logic [7:0] FULL_SCALE_MAX = 8'hFF;

    // one register access from the host side
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pomc_req_t;

    // settings latched for one proximity cycle
    typedef struct packed {
        logic [7:0] offset_ur;
        logic [7:0] offset_dl;
        logic [3:0] mask_udlr;
        logic       gain_boost;
    } pomc_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CONV  = 3'b010,
        ST_SLEEP = 3'b100
    } pomc_state_t;
endpackage

//--- test/pomc_core_assertions.sv
// pomc_chk: port-level timing checks for pomc_core.
// assumes it is bound onto pomc_core.
`timescale 1ns/100ps
module pomc_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // register port
    input wire pomc_pkg::pomc_req_t req,
    input wire logic [7:0] rdata,
    // front end
    input wire logic cycle_start,
    input wire logic cycle_done,
    input wire logic irq_level,
    input wire logic sleep_decision,
    // results
    input wire logic [7:0] proximity_result,
    input wire logic result_valid,
    input wire logic low_power,
    input wire logic converting
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    done_to_valid_a: assert property (converting && cycle_done |=> result_valid)
        else $error("no result after conversion end");
    valid_pulse_a: assert property (result_valid |=> !result_valid)
        else $error("result valid longer than one cycle");
    result_hold_a: assert property (!result_valid |-> $stable(proximity_result))
        else $error("result changed without valid");
    start_conv_a: assert property (!converting && !low_power && cycle_start
        && !sleep_decision |=> converting)
        else $error("cycle start not taken in idle");
    conv_end_a: assert property (converting && cycle_done |=> !converting)
        else $error("still converting after done");
    cfg_reserved_a: assert property (req.rd && req.addr == 8'h9F |=> rdata[7:6] == 2'h0)
        else $error("reserved config bits read nonzero");
    sleep_entry_a: assert property ($rose(low_power) |-> $past(sleep_decision)
        && $past(irq_level))
        else $error("sleep without decision and irq");
    sleep_hold_a: assert property (low_power && irq_level |=> low_power)
        else $error("sleep left with irq pending");
    sleep_exit_a: assert property (low_power && !irq_level |=> !low_power)
        else $error("sleep kept after irq cleared");
endmodule

//--- test/pomc_fe_model.sv
// pomc_fe_model: analog front end stand-in, starts a cycle, returns samples.
// assumes go is a one-cycle pulse from the bench.
`timescale 1ns/100ps
module pomc_fe_model #(parameter int DLY = 8) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // control
    input wire logic go,
    input wire logic converting,
    input wire logic [31:0] samp,
    // to the block
    output logic cycle_start,
    output logic cycle_done,
    output logic [31:0] raw_udlr
);
    int cnt = 0;
    // inverted outside the done cycle so stale sampling shows up
    assign raw_udlr = cycle_done ? samp : ~samp;
    always @(posedge sys_clk) begin
        cycle_start <= go && !srst;
        cycle_done <= converting && cnt == DLY;
        cnt <= converting ? cnt + 1 : 0;
    end
endmodule

//--- test/pomc_tb.sv
// tb: register and proximity-cycle sequences for pomc_core.
// assumes pomc_fe_model stands in for the analog front end.
`timescale 1ns/100ps
module tb;
    logic sys_clk = 1'h0, srst = 1'h1, go = 1'h0, irq_level = 1'h0, sleep_decision = 1'h0;
    pomc_pkg::pomc_req_t req = '0;
    logic [31:0] samp = 32'h0, raw;
    logic [7:0] rdata, proximity_result;
    logic cycle_start, cycle_done, result_valid, low_power, converting;
    int fails = 0, comparisons = 0, cyc = 0;
    localparam logic [7:0] CFG [7] = '{8'h00, 8'h08, 8'h08, 8'h25, 8'h2A, 8'h00, 8'h05};
    localparam logic [15:0] OFS [7] = '{16'h0A85, 16'h0, 16'h0, 16'h0, 16'h0, 16'h7FFF, 16'h0};
    localparam logic [31:0] SMP [7] = '{32'h28140A1E, 32'h64140A1E, 32'hFFFA00FA,
        32'hFA00FAFF, 32'h631E6328, 32'h0A00000A, 32'h3CC828C8};
    localparam logic [7:0] EXP [7] = '{8'h2F, 8'h1E, 8'h7F, 8'hFF, 8'h46, 8'h3F, 8'h32};
    pomc_core DUT (.sys_clk(sys_clk), .srst(srst), .req(req), .rdata(rdata),
        .cycle_start(cycle_start), .cycle_done(cycle_done), .raw_up(raw[31:24]),
        .raw_down(raw[23:16]), .raw_left(raw[15:8]), .raw_right(raw[7:0]),
        .irq_level(irq_level), .sleep_decision(sleep_decision),
        .proximity_result(proximity_result), .result_valid(result_valid),
        .low_power(low_power), .converting(converting));
    pomc_fe_model #(.DLY(8)) u_fe (.sys_clk(sys_clk), .srst(srst), .go(go),
        .converting(converting), .samp(samp), .cycle_start(cycle_start),
        .cycle_done(cycle_done), .raw_udlr(raw));
    task automatic print_verdict();
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) req <= '{1'h1, 1'h0, a, d};
        @(posedge sys_clk) req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk) req <= '{1'h0, 1'h1, a, 8'h00};
        @(posedge sys_clk) req <= '0;
        @(posedge sys_clk) #1 check(rdata, e);
    endtask
    task automatic start(input logic [31:0] s);
        @(posedge sys_clk) samp <= s;
        go <= 1'h1;
        @(posedge sys_clk) go <= 1'h0;
    endtask
    task automatic fin(input logic [7:0] e);
        for (int i = 0; i < 40 && result_valid !== 1'h1; i++) @(posedge sys_clk) #1;
        check({7'h00, result_valid}, 8'h01);
        check(proximity_result, e);
    endtask
    task automatic sleep_try(input logic [7:0] e);
        @(posedge sys_clk) irq_level <= 1'h1;
        sleep_decision <= 1'h1;
        @(posedge sys_clk) sleep_decision <= 1'h0;
        @(posedge sys_clk) #1 check({7'h00, low_power}, e);
    endtask
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'h0;
        rd(8'h9D, 8'h00);
        rd(8'h9E, 8'h00);
        rd(8'h9F, 8'h00);
        rd(8'hA0, 8'h00);
        wr(8'h9F, 8'h3F);
        rd(8'h9F, 8'h3F);
        // boost only with the recommended masks
        for (int k = 0; k < 7; k++) begin
            wr(8'h9D, OFS[k][15:8]);
            wr(8'h9E, OFS[k][7:0]);
            wr(8'h9F, CFG[k]);
            start(SMP[k]);
            fin(EXP[k]);
        end
        wr(8'h9D, 8'h00);
        wr(8'h9E, 8'h00);
        wr(8'h9F, 8'h00);
        start(32'h0A0A0A0A);
        wr(8'h9D, 8'h14);
        fin(8'h14);
        start(32'h0A0A0A0A);
        fin(8'h0A);
        wr(8'h9F, 8'h10);
        sleep_try(8'h01);
        start(32'h0A0A0A0A);
        repeat (3) @(posedge sys_clk);
        #1 check({6'h00, converting, low_power}, 8'h01);
        @(posedge sys_clk) irq_level <= 1'h0;
        repeat (2) @(posedge sys_clk);
        #1 check({7'h00, low_power}, 8'h00);
        wr(8'h9F, 8'h00);
        sleep_try(8'h00);
        print_verdict();
    end
endmodule
bind pomc_core pomc_chk u_chk (.sys_clk(sys_clk), .srst(srst), .req(req), .rdata(rdata),
    .cycle_start(cycle_start), .cycle_done(cycle_done), .irq_level(irq_level),
    .sleep_decision(sleep_decision), .proximity_result(proximity_result),
    .result_valid(result_valid), .low_power(low_power), .converting(converting));
